// >>> include/cfg_access_pkg.sv
/*
 Shared constants and carriers for the configuration access requester:
 message tokens, destination words, field sizes, command and result records.
 Assumes a byte-wide token link in which every token carries a control flag.
*/
package cfg_access_pkg;

    // Clock rate of the requester
    localparam int unsigned CLK_HZ          = 10_000_000;

    // Control token values
    localparam logic [7:0]  TOK_TILE_WR     = 8'hC0;
    localparam logic [7:0]  TOK_TILE_RD     = 8'hC1;
    localparam logic [7:0]  TOK_PER_WR      = 8'h24;
    localparam logic [7:0]  TOK_PER_RD      = 8'h25;
    localparam logic [7:0]  TOK_END         = 8'h01;
    localparam logic [7:0]  TOK_ACK         = 8'h03;
    localparam logic [7:0]  TOK_NAK         = 8'h04;

    // Channel destination low parts
    localparam logic [15:0] DEST_TILE_LO    = 16'hC20C;
    localparam logic [15:0] DEST_NODE_LO    = 16'hC30C;
    localparam logic [7:0]  DEST_PER_LO     = 8'h02;

    // Processor status resource identifier
    localparam int unsigned PS_RES_SHIFT    = 8;
    localparam logic [31:0] PS_RES_TAG      = 32'h0000000B;

    // Return identifier low byte that suppresses the reply
    localparam logic [7:0]  NOREPLY_BYTE    = 8'hFF;

    // Field byte counts
    localparam logic [2:0]  RET_BYTES       = 3'h3;
    localparam logic [2:0]  REGN_BYTES      = 3'h2;
    localparam logic [2:0]  PREG_BYTES      = 3'h1;
    localparam logic [2:0]  SIZE_BYTES      = 3'h1;
    localparam logic [2:0]  WORD_BYTES      = 3'h4;
    localparam int unsigned BYTE_W          = 8;

    // Request kinds
    typedef enum logic [2:0] {
        KIND_TILE_WR = 3'h0,
        KIND_TILE_RD = 3'h1,
        KIND_NODE_WR = 3'h2,
        KIND_NODE_RD = 3'h3,
        KIND_PER_WR  = 3'h4,
        KIND_PER_RD  = 3'h5,
        KIND_PS      = 3'h6
    } kind_t;

    // One link token: control flag plus byte
    typedef struct packed {
        logic       ctrl;
        logic [7:0] val;
    } token_t;

    // Request from the user side
    typedef struct packed {
        kind_t       kind;
        logic [15:0] target;
        logic [7:0]  periph;
        logic [23:0] ret_id;
        logic [15:0] regn;
        logic [7:0]  size;
        logic [31:0] data;
    } cmd_t;

    // Outcome of one request
    typedef struct packed {
        logic        ok;
        logic        proto_err;
        logic        no_reply;
        logic [31:0] rdata;
        logic [7:0]  rbytes;
    } result_t;

endpackage

// >>> src/byte_shifter.sv
/*
 Loadable word that hands out its bytes most significant first.
 Assumes the caller loads only while no byte of the old word is pending.
*/
`timescale 1ns/1ps
`default_nettype none

module byte_shifter #(
    parameter int unsigned N_BYTES = 4,
    parameter int unsigned CNT_W   = $clog2(N_BYTES + 1)
) (
    // Clock, reset, enable
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   ce,
    // Load side
    input  wire logic                   load,
    input  wire logic [N_BYTES*8-1:0]   load_word,
    input  wire logic [CNT_W-1:0]       load_n,
    // Drain side
    input  wire logic                   step,
    output logic      [7:0]             byte_o,
    output logic                        last
);

    logic [N_BYTES*8-1:0] word_ff;
    logic [CNT_W-1:0]     cnt_ff;

    // Top byte is always the next one out
    assign byte_o = word_ff[N_BYTES*8-1 -: 8];
    assign last   = (cnt_ff == CNT_W'(1));

    // Load wins over step so a new field starts cleanly
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            word_ff <= '0;
            cnt_ff  <= '0;
        end else if (ce) begin
            if (load) begin
                word_ff <= load_word;
                cnt_ff  <= load_n;
            end else if (step && cnt_ff != '0) begin
                word_ff <= {word_ff[N_BYTES*8-9:0], 8'h00};
                cnt_ff  <= cnt_ff - CNT_W'(1);
            end
        end
    end

endmodule
`default_nettype wire

// >>> src/cfg_access_host.sv
/*
 Requester for configuration register access over a token link.
 Takes one command, sets the channel destination, sends the request
 message token by token and parses the reply into a result record.
 Assumes the link partner runs on clk and uses valid/ready per token.
*/
// Functional notes
// - Every request carries 24-bit return identifier
// - Low byte all ones: no reply awaited; the code applies this to writes only and still awaits a reply on reads
// - Multi-byte fields go most significant first
// - Status resource id: number shl 8 or 0x0B
// - Tile destination: tile id over C20C
// - Node destination: node id over C30C
// - Write: 192, return, reg16, data32, 1
// - Read: 193, return, reg16, 1
// - Peripheral destination: node, periph, 02
// - Periph write: 36, return, reg8, size, data, 1
// - Periph read: 37, return, reg8, size, 1
`timescale 1ns/1ps
`default_nettype none

module cfg_access_host
    import cfg_access_pkg::*;
#(
    parameter int unsigned DATA_BYTES_MAX = 4
) (
    // Clock, reset, enable
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    // Command port
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire cmd_t       cmd,
    // Result port
    output logic            res_valid,
    output result_t         res,
    // Channel destination and status resource
    output logic [31:0]     dest,
    output logic [31:0]     ps_res_id,
    // Outgoing tokens
    output logic            tx_valid,
    input  wire logic       tx_ready,
    output token_t          tx_tok,
    // Incoming tokens
    input  wire logic       rx_valid,
    output logic            rx_ready,
    input  wire token_t     rx_tok
);

    // Peripheral data is carried in one word, so at most four bytes
    generate
        if (DATA_BYTES_MAX < 1 || DATA_BYTES_MAX > 4) begin : g_bad_max
            $error("DATA_BYTES_MAX must be 1 to 4");
        end
    endgenerate

    localparam logic [2:0] MAX_N = 3'(DATA_BYTES_MAX);

    // Gray along the usual path
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_HEAD  = 4'h1,
        ST_RETID = 4'h3,
        ST_REGN  = 4'h2,
        ST_SIZE  = 4'h6,
        ST_DATA  = 4'h7,
        ST_TAIL  = 4'h5,
        ST_RSP   = 4'h4,
        ST_RDAT  = 4'hC,
        ST_RFAIL = 4'hD,
        ST_FIN   = 4'hF
    } state_t;

    state_t      state_ff;
    state_t      nxt_state;
    cmd_t        cmd_ff;
    token_t      tx_tok_ff;
    logic        tx_valid_ff;
    logic        ok_ff;
    logic        err_ff;
    logic        noreply_ff;
    logic [31:0] rdata_ff;
    logic [7:0]  rbytes_ff;
    logic        res_valid_ff;
    logic [31:0] dest_ff;
    logic [31:0] ps_res_ff;

    // Command decode
    wire logic   is_per    = (cmd_ff.kind == KIND_PER_WR) || (cmd_ff.kind == KIND_PER_RD);
    wire logic   is_wr     = (cmd_ff.kind == KIND_TILE_WR) || (cmd_ff.kind == KIND_NODE_WR)
                             || (cmd_ff.kind == KIND_PER_WR);
    wire logic   no_reply  = is_wr && (cmd_ff.ret_id[7:0] == NOREPLY_BYTE);
    // Oversize peripheral writes are clipped to the word we hold
    wire logic [2:0] per_n = (cmd_ff.size > 8'(MAX_N)) ? MAX_N : cmd_ff.size[2:0];
    wire logic [4:0] per_sh = 5'({2'b00, WORD_BYTES - per_n} << 3);

    // Handshakes
    wire logic   tx_free   = !tx_valid_ff || tx_ready;
    wire logic   sending   = (state_ff == ST_HEAD) || (state_ff == ST_RETID)
                             || (state_ff == ST_REGN) || (state_ff == ST_SIZE)
                             || (state_ff == ST_DATA) || (state_ff == ST_TAIL);
    wire logic   adv       = ce && tx_free && sending;
    wire logic   cmd_fire  = ce && cmd_valid && (state_ff == ST_IDLE);
    wire logic   rx_open   = (state_ff == ST_RSP) || (state_ff == ST_RDAT)
                             || (state_ff == ST_RFAIL);
    wire logic   rx_fire   = ce && rx_valid && rx_open;

    assign cmd_ready = ce && (state_ff == ST_IDLE);
    assign rx_ready  = ce && rx_open;

    // control tokens by type flag and value
    wire logic   rx_end    = rx_tok.ctrl && (rx_tok.val == TOK_END);
    wire logic   rx_ack    = rx_tok.ctrl && (rx_tok.val == TOK_ACK);
    wire logic   rx_nak    = rx_tok.ctrl && (rx_tok.val == TOK_NAK);

    // Field shifter
    logic [31:0] fld_word;
    logic [2:0]  fld_n;
    logic [7:0]  sh_byte;
    logic        sh_last;
    wire logic   fld_load  = adv && (nxt_state != state_ff)
                             && ((nxt_state == ST_RETID) || (nxt_state == ST_REGN)
                             || (nxt_state == ST_SIZE) || (nxt_state == ST_DATA));
    wire logic   fld_step  = adv && !fld_load;

    // fields left aligned so the top byte leaves first
    always_comb begin
        fld_word = 32'h0;
        fld_n    = 3'h0;
        case (nxt_state)
            ST_RETID: begin
                fld_word = {cmd_ff.ret_id, 8'h00};
                fld_n    = RET_BYTES;
            end
            ST_REGN: begin
                fld_word = is_per ? {cmd_ff.regn[7:0], 24'h0} : {cmd_ff.regn, 16'h0};
                fld_n    = is_per ? PREG_BYTES : REGN_BYTES;
            end
            ST_SIZE: begin
                fld_word = {cmd_ff.size, 24'h0};
                fld_n    = SIZE_BYTES;
            end
            ST_DATA: begin
                fld_word = is_per ? (cmd_ff.data << per_sh) : cmd_ff.data;
                fld_n    = is_per ? per_n : WORD_BYTES;
            end
            default: begin
                fld_word = 32'h0;
                fld_n    = 3'h0;
            end
        endcase
    end

    byte_shifter #(
        .N_BYTES (4),
        .CNT_W   (3)
    ) u_shift (
        .clk       (clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .load      (fld_load),
        .load_word (fld_word),
        .load_n    (fld_n),
        .step      (fld_step),
        .byte_o    (sh_byte),
        .last      (sh_last)
    );

    // Message sequencing
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:  if (cmd_fire) begin
                nxt_state = (cmd.kind == KIND_PS) ? ST_FIN : ST_HEAD;
            end
            ST_HEAD:  if (adv) begin
                nxt_state = ST_RETID;
            end
            ST_RETID: if (adv && sh_last) begin
                nxt_state = ST_REGN;
            end
            // tile and node layout; peripheral layout
            ST_REGN:  if (adv && sh_last) begin
                nxt_state = is_per ? ST_SIZE : (is_wr ? ST_DATA : ST_TAIL);
            end
            ST_SIZE:  if (adv && sh_last) begin
                nxt_state = (is_wr && per_n != 3'h0) ? ST_DATA : ST_TAIL;
            end
            ST_DATA:  if (adv && sh_last) begin
                nxt_state = ST_TAIL;
            end
            ST_TAIL:  if (adv) begin
                nxt_state = no_reply ? ST_FIN : ST_RSP;
            end
            ST_RSP:   if (rx_fire) begin
                nxt_state = rx_ack ? ST_RDAT : (rx_nak ? ST_RFAIL : ST_FIN);
            end
            ST_RDAT:  if (rx_fire && rx_tok.ctrl) begin
                nxt_state = ST_FIN;
            end
            ST_RFAIL: if (rx_fire) begin
                nxt_state = ST_FIN;
            end
            ST_FIN:   nxt_state = ST_IDLE;
            default:  nxt_state = ST_IDLE;
        endcase
    end

    // Token for the current sending state
    logic [7:0] head_val;
    always_comb begin
        case (cmd_ff.kind)
            KIND_TILE_RD, KIND_NODE_RD: head_val = TOK_TILE_RD;
            KIND_PER_WR:                head_val = TOK_PER_WR;
            KIND_PER_RD:                head_val = TOK_PER_RD;
            default:                    head_val = TOK_TILE_WR;
        endcase
    end
    wire token_t nxt_tok = (state_ff == ST_HEAD) ? token_t'{ctrl: 1'b1, val: head_val}
                         : (state_ff == ST_TAIL) ? token_t'{ctrl: 1'b1, val: TOK_END}
                         : token_t'{ctrl: 1'b0, val: sh_byte};

    // Destination words for the three target kinds
    wire logic [31:0] nxt_dest =
        ((cmd.kind == KIND_PER_WR) || (cmd.kind == KIND_PER_RD))
            ? {cmd.target, cmd.periph, DEST_PER_LO}
        : ((cmd.kind == KIND_NODE_WR) || (cmd.kind == KIND_NODE_RD))
            ? {cmd.target, DEST_NODE_LO}
            : {cmd.target, DEST_TILE_LO};
    wire logic [31:0] nxt_ps = ({16'h0, cmd.regn} << PS_RES_SHIFT) | PS_RES_TAG;

    // State, command capture and destination
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff  <= ST_IDLE;
            cmd_ff    <= '0;
            dest_ff   <= 32'h0;
            ps_res_ff <= 32'h0;
        end else if (ce) begin
            state_ff <= nxt_state;
            if (cmd_fire) begin
                cmd_ff <= cmd;
                if (cmd.kind == KIND_PS) begin
                    ps_res_ff <= nxt_ps;
                end else begin
                    dest_ff <= nxt_dest;
                end
            end
        end
    end

    // Output token stage; holds until the link takes it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_valid_ff <= 1'b0;
            tx_tok_ff   <= '0;
        end else if (ce && tx_free) begin
            tx_valid_ff <= sending;
            if (sending) begin
                tx_tok_ff <= nxt_tok;
            end
        end
    end

    // Reply parsing; a stray token marks the exchange broken
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ok_ff      <= 1'b0;
            err_ff     <= 1'b0;
            noreply_ff <= 1'b0;
            rdata_ff   <= 32'h0;
            rbytes_ff  <= 8'h00;
        end else if (ce) begin
            if (cmd_fire) begin
                ok_ff      <= (cmd.kind == KIND_PS);
                err_ff     <= 1'b0;
                noreply_ff <= 1'b0;
                rdata_ff   <= 32'h0;
                rbytes_ff  <= 8'h00;
            end else if (adv && state_ff == ST_TAIL && no_reply) begin
                ok_ff      <= 1'b1;
                noreply_ff <= 1'b1;
            end else if (rx_fire) begin
                case (state_ff)
                    ST_RSP:   err_ff <= !(rx_ack || rx_nak);
                    ST_RDAT:  if (!rx_tok.ctrl) begin
                        rdata_ff  <= {rdata_ff[23:0], rx_tok.val};
                        rbytes_ff <= (rbytes_ff == 8'hFF) ? rbytes_ff : rbytes_ff + 8'h01;
                    end else if (rx_end) begin
                        // Tile and node reads must bring a whole word
                        ok_ff  <= is_wr || is_per || (rbytes_ff == 8'(WORD_BYTES));
                        err_ff <= !(is_wr || is_per || (rbytes_ff == 8'(WORD_BYTES)));
                    end else begin
                        err_ff <= 1'b1;
                    end
                    // failure pair closes with end token
                    ST_RFAIL: err_ff <= !rx_end;
                    default:  err_ff <= err_ff;
                endcase
            end
        end
    end

    // Result strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            res_valid_ff <= 1'b0;
        end else if (ce) begin
            res_valid_ff <= (state_ff == ST_FIN);
        end
    end

    assign tx_valid  = tx_valid_ff;
    assign tx_tok    = tx_tok_ff;
    assign dest      = dest_ff;
    assign ps_res_id = ps_res_ff;
    assign res_valid = res_valid_ff;
    assign res       = '{ok: ok_ff, proto_err: err_ff, no_reply: noreply_ff,
                         rdata: rdata_ff, rbytes: rbytes_ff};

endmodule
`default_nettype wire

// >>> test/cfg_access_monitor.sv
/*
 Checker for the configuration access requester, bound to its top module.
 Assumes one clock, ce held high during traffic and the reply order kept.
*/
`timescale 1ns/1ps
`default_nettype none

module cfg_access_monitor
    import cfg_access_pkg::*;
(
    // Clock, reset, enable
    input wire logic    clk,
    input wire logic    rst_b,
    input wire logic    ce,
    // Command and result
    input wire logic    cmd_valid,
    input wire logic    cmd_ready,
    input wire cmd_t    cmd,
    input wire logic    res_valid,
    input wire result_t res,
    input wire logic [31:0] dest,
    input wire logic [31:0] ps_res_id,
    // Token links
    input wire logic    tx_valid,
    input wire logic    tx_ready,
    input wire token_t  tx_tok,
    input wire logic    rx_valid,
    input wire logic    rx_ready,
    input wire token_t  rx_tok
);
    cmd_t        cmd_ff;
    logic [3:0]  idx_ff;
    logic        first_ff;
    logic        ack_ff;
    logic        nak_ff;
    logic        take;
    logic        link;
    logic        wr;
    logic [7:0]  ret_byte;
    logic [7:0]  head_exp;
    logic [31:0] dest_exp;

    // Expected fields of the command last taken
    assign take = cmd_valid && cmd_ready;
    assign link = cmd_ff.kind != KIND_PS;
    assign wr = cmd_ff.kind inside {KIND_TILE_WR, KIND_NODE_WR, KIND_PER_WR};
    assign ret_byte = (idx_ff == 4'h1) ? cmd_ff.ret_id[23:16] :
                      (idx_ff == 4'h2) ? cmd_ff.ret_id[15:8] : cmd_ff.ret_id[7:0];
    assign head_exp = (cmd_ff.kind == KIND_PER_WR) ? TOK_PER_WR :
                      (cmd_ff.kind == KIND_PER_RD) ? TOK_PER_RD :
                      wr ? TOK_TILE_WR : TOK_TILE_RD;
    assign dest_exp = (cmd_ff.kind inside {KIND_PER_WR, KIND_PER_RD}) ?
                      {cmd_ff.target, cmd_ff.periph, DEST_PER_LO} :
                      (cmd_ff.kind inside {KIND_TILE_WR, KIND_TILE_RD}) ?
                      {cmd_ff.target, DEST_TILE_LO} : {cmd_ff.target, DEST_NODE_LO};

    // Token index and first reply token; take wins over a late tail
    always_ff @(posedge clk) begin
        if (!rst_b || take) begin
            cmd_ff <= rst_b ? cmd : '0;
            idx_ff <= rst_b ? 4'h0 : 4'hF;
            first_ff <= rst_b;
            ack_ff <= 1'b0;
            nak_ff <= 1'b0;
        end else begin
            if (tx_valid && tx_ready && idx_ff != 4'hF) idx_ff <= idx_ff + 4'h1;
            if (rx_valid && rx_ready && first_ff) begin
                first_ff <= 1'b0;
                ack_ff <= rx_tok.ctrl && rx_tok.val == TOK_ACK;
                nak_ff <= rx_tok.ctrl && rx_tok.val == TOK_NAK;
            end
        end
    end

    // Single clock domain, so one clock and reset guard for all
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_head_token: assert property (
        tx_valid && idx_ff == 4'h0 && link |-> tx_tok.ctrl && tx_tok.val == head_exp)
        else $error("head token wrong");
    a_ret_bytes: assert property (
        tx_valid && idx_ff inside {[4'h1:4'h3]} |-> !tx_tok.ctrl && tx_tok.val == ret_byte)
        else $error("return byte wrong");
    a_ctrl_place: assert property (
        tx_valid && tx_tok.ctrl |-> idx_ff == 4'h0 || tx_tok.val == TOK_END)
        else $error("control token out of place");
    a_tx_hold: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_tok))
        else $error("token dropped before taken");
    a_dest_word: assert property (
        res_valid && link |-> dest == dest_exp)
        else $error("destination word wrong");
    a_ps_quick: assert property (
        take && cmd.kind == KIND_PS |-> !tx_valid ##1 !tx_valid ##1 res_valid)
        else $error("status access slow or on link");
    a_ps_ident: assert property (
        res_valid && !link |-> ps_res_id == (({16'h0000, cmd_ff.regn} << PS_RES_SHIFT) | PS_RES_TAG))
        else $error("status resource id wrong");
    a_noreply_ok: assert property (
        res_valid && res.no_reply |-> wr && cmd_ff.ret_id[7:0] == NOREPLY_BYTE && res.ok)
        else $error("no reply flag wrong");
    a_ack_ok: assert property (
        res_valid && link && res.ok && !res.no_reply |-> ack_ff)
        else $error("success without ack");
    a_nak_fail: assert property (
        res_valid && nak_ff |-> !res.ok ##1 !res_valid)
        else $error("failure reply not reported");
endmodule

bind cfg_access_host cfg_access_monitor mon (.*);

`default_nettype wire

// >>> test/cfg_target_model.sv
/*
 Behavioural configuration target: collects request tokens, replies.
 Assumes the requester runs on clk; mode 1 fails, mode 2 sends junk.
*/
`timescale 1ns/1ps
`default_nettype none

module cfg_target_model
    import cfg_access_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // Behaviour controls
    input wire logic [1:0]  mode,
    input wire logic        slow,
    input wire logic [31:0] rd_word,
    // Request tokens
    input wire logic        tx_valid,
    output logic            tx_ready,
    input wire token_t      tx_tok,
    // Reply tokens
    output logic            rx_valid,
    input wire logic        rx_ready,
    output token_t          rx_tok
);
    token_t req_q[$];
    token_t rsp_q[$];
    int     n_rsp;

    // Builds the reply once the tail of a request is in
    task automatic reply();
        logic [7:0] hd;
        int         nb;
        hd = req_q[0].val;
        if ((hd == TOK_TILE_WR || hd == TOK_PER_WR) && req_q[3].val == NOREPLY_BYTE) return;
        n_rsp++;
        if (mode == 2'h1) begin
            rsp_q.push_back('{1'b1, TOK_NAK});
            rsp_q.push_back('{1'b1, TOK_END});
            return;
        end
        // data byte carrying the ack value
        if (mode == 2'h2) begin
            rsp_q.push_back('{1'b0, TOK_ACK});
            return;
        end
        nb = (hd == TOK_TILE_RD) ? 4 : (hd != TOK_PER_RD) ? 0 :
             (req_q[5].val > 8'h04) ? 4 : int'(req_q[5].val);
        rsp_q.push_back('{1'b1, TOK_ACK});
        for (int i = nb - 1; i >= 0; i--) rsp_q.push_back('{1'b0, rd_word[i*8+:8]});
        rsp_q.push_back('{1'b1, TOK_END});
    endtask

    // Slow mode halves the accept rate to stretch token holds
    always @(posedge clk) begin
        if (!rst_b) begin
            tx_ready <= 1'b0;
            rx_valid <= 1'b0;
            rx_tok <= '0;
            rsp_q.delete();
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
            // tail known by its control flag and end value
            if (tx_valid && tx_ready) begin
                req_q.push_back(tx_tok);
                if (tx_tok.ctrl && tx_tok.val == TOK_END) reply();
            end
            // Released lines show the inverse so stale values never match
            if (rx_valid && rx_ready) begin
                rx_valid <= 1'b0;
                rx_tok <= ~rx_tok;
            end else if (!rx_valid && rsp_q.size() != 0) begin
                rx_valid <= 1'b1;
                rx_tok <= rsp_q.pop_front();
            end
        end
    end
endmodule

`default_nettype wire

// >>> test/cfg_access_host_tb_top.sv
/*
 Self-checking bench for the configuration access requester.
 Assumes the target model on the far link and ce held high.
*/
`timescale 1ns/1ps
`default_nettype none

module cfg_access_host_tb_top;
    import cfg_access_pkg::*;

    logic        clk, rst_b, ce, cmd_valid, cmd_ready, res_valid, slow;
    logic        tx_valid, tx_ready, rx_valid, rx_ready;
    logic [1:0]  mode;
    logic [31:0] dest, ps_res_id, rd_word;
    cmd_t        cmd;
    result_t     res, got;
    token_t      tx_tok, rx_tok;
    token_t      exp_q[$];
    int          n_mismatch = 0, comparisons = 0;

    cfg_access_host #(.DATA_BYTES_MAX(4)) dut (.*);
    cfg_target_model model (.*);

    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    // Pushes n bytes of v, most significant first
    task automatic put(logic c, logic [31:0] v, int n);
        for (int i = n - 1; i >= 0; i--) exp_q.push_back('{c, v[i*8+:8]});
    endtask

    task automatic head(logic [7:0] tok, logic [23:0] ret);
        exp_q.delete();
        put(1'b1, {24'h0, tok}, 1);
        put(1'b0, {8'h00, ret}, 3);
    endtask

    // Every message closes with the end token
    task automatic chk_req();
        put(1'b1, {24'h0, TOK_END}, 1);
        chk("req_len", exp_q.size(), model.req_q.size());
        for (int i = 0; i < exp_q.size() && i < model.req_q.size(); i++)
            chk("req_tok", {23'h0, exp_q[i]}, {23'h0, model.req_q[i]});
    endtask

    // One command at negedge, then a bounded wait for its result
    task automatic run(kind_t k, logic [15:0] rg, logic [23:0] ret, logic [7:0] sz,
                       logic [31:0] d);
        int t;
        @(negedge clk);
        model.req_q.delete();
        model.n_rsp = 0;
        cmd = '{k, 16'h3A5C, 8'h6E, ret, rg, sz, d};
        while (cmd_ready !== 1'b1) @(negedge clk);
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        t = 0;
        while (res_valid !== 1'b1 && t < 300) begin
            @(negedge clk);
            t++;
        end
        chk("res_valid", 32'h1, {31'h0, res_valid});
        got = res;
        repeat (3) @(negedge clk);
    endtask

    task automatic t_tile_wr();
        run(KIND_TILE_WR, 16'h1234, 24'h0A0B0C, 8'h00, 32'hDEADBEEF);
        head(TOK_TILE_WR, 24'h0A0B0C);
        put(1'b0, 32'h1234, 2);
        put(1'b0, 32'hDEADBEEF, 4);
        chk_req();
        chk("ok", 32'h1, {31'h0, got.ok});
        chk("dest", {16'h3A5C, DEST_TILE_LO}, dest);
    endtask

    task automatic t_node_rd();
        rd_word = 32'h5A6B7C8D;
        run(KIND_NODE_RD, 16'h0207, 24'h123456, 8'h00, 32'h0);
        head(TOK_TILE_RD, 24'h123456);
        put(1'b0, 32'h0207, 2);
        chk_req();
        chk("rdata", 32'h5A6B7C8D, got.rdata);
        chk("rbytes", 32'h4, {24'h0, got.rbytes});
        chk("dest", {16'h3A5C, DEST_NODE_LO}, dest);
    endtask

    task automatic t_noreply();
        run(KIND_TILE_WR, 16'h0010, 24'h1234FF, 8'h00, 32'h01020304);
        chk("no_reply", 32'h1, {31'h0, got.no_reply});
        chk("replies", 32'h0, model.n_rsp);
    endtask

    task automatic t_node_nak();
        mode = 2'h1;
        run(KIND_NODE_WR, 16'h0099, 24'h00AB01, 8'h00, 32'h55AA55AA);
        chk("ok", 32'h0, {31'h0, got.ok});
        chk("proto_err", 32'h0, {31'h0, got.proto_err});
        mode = 2'h0;
    endtask

    task automatic t_per_wr();
        slow = 1'b1;
        run(KIND_PER_WR, 16'h0033, 24'h010203, 8'h02, 32'hA1B2C3D4);
        head(TOK_PER_WR, 24'h010203);
        put(1'b0, 32'h33, 1);
        put(1'b0, 32'h02, 1);
        put(1'b0, 32'hC3D4, 2);
        chk_req();
        chk("dest", {16'h3A5C, 8'h6E, DEST_PER_LO}, dest);
        chk("ok", 32'h1, {31'h0, got.ok});
        slow = 1'b0;
    endtask

    task automatic t_per_rd();
        rd_word = 32'h11223344;
        run(KIND_PER_RD, 16'h0041, 24'h0A0000, 8'h03, 32'h0);
        head(TOK_PER_RD, 24'h0A0000);
        put(1'b0, 32'h41, 1);
        put(1'b0, 32'h03, 1);
        chk_req();
        chk("rbytes", 32'h3, {24'h0, got.rbytes});
        chk("rdata", 32'h223344, {8'h0, got.rdata[23:0]});
    endtask

    task automatic t_bad_first();
        mode = 2'h2;
        run(KIND_TILE_RD, 16'h0001, 24'h000102, 8'h00, 32'h0);
        chk("proto_err", 32'h1, {31'h0, got.proto_err});
        chk("ok", 32'h0, {31'h0, got.ok});
        mode = 2'h0;
    endtask

    task automatic t_ps();
        run(KIND_PS, 16'h0012, 24'h0, 8'h00, 32'h0);
        chk("ps_res_id", 32'h0000120B, ps_res_id);
        chk("link_tokens", 32'h0, model.req_q.size());
    endtask

    task automatic end_of_test();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Clock at 10 MHz
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end

    // Main sequence
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        mode = 2'h0;
        slow = 1'b0;
        rd_word = 32'h0;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        t_tile_wr();
        t_node_rd();
        t_noreply();
        t_node_nak();
        t_per_wr();
        t_per_rd();
        t_bad_first();
        t_ps();
        end_of_test();
    end
endmodule

`default_nettype wire
